/* pkg/mem_protect_pkg.sv */
/*
 Constants, field layouts and types shared by the memory protection block.
 Assumes a 32-bit register bus with one aligned word per register.
*/
package mem_protect_pkg;

    // Register offsets within the block's configuration space
    localparam logic [11:0] PAGE_BASE_OFS = 12'h000;
    localparam logic [11:0] FAULT_ADDR_OFS = 12'h100;
    localparam logic [11:0] FAULT_STAT_OFS = 12'h104;
    localparam logic [11:0] FAULT_CLR_OFS = 12'h108;
    localparam logic [11:0] LOCK_CTL_OFS = 12'h10C;

    // Field positions
    localparam logic [31:0] PA_USED_MASK = 32'h0000_FF3F;
    localparam int PA_ID0_BIT = 10;
    localparam int PA_ID_OTHER_BIT = 9;
    localparam int PA_LOCAL_BIT = 8;
    localparam int FS_ID_LSB = 9;
    localparam int FS_ID_W = 7;
    localparam int FS_LOCAL_BIT = 8;
    localparam int FAULT_CLR_BIT = 0;
    localparam int LOCK_ENGAGE_BIT = 0;
    localparam int LOCK_RELEASE_BIT = 1;
    localparam int NUM_DIRECT_IDS = 6;

    // Reset values
    localparam logic [31:0] FAULT_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] FAULT_STAT_RESET = 32'h0000_0000;

    // Access type codes, bit 5 supervisor read down to bit 0 user fetch
    localparam logic [5:0] ACC_LINE_FILL = 6'h3F;
    localparam logic [5:0] ACC_WRITEBACK = 6'h12;

    typedef enum logic [1:0] {
        KIND_READ = 2'b00,
        KIND_WRITE = 2'b01,
        KIND_FETCH = 2'b10
    } req_kind_e;

    typedef enum logic {
        FAULT_EMPTY = 1'b0,
        FAULT_HELD = 1'b1
    } fault_state_e;

endpackage

/* rtl/ahb_reg_slave.sv */
/*
 AHB-Lite slave front end for the protection registers.
 Assumes single word transfers; zero wait states, response always OKAY.
*/
`timescale 1ns/1ps
module ahb_reg_slave
    import mem_protect_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [3:0] hprot,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register side
    output logic [11:0] rdAddr,
    input wire logic [31:0] rdData,
    output logic wrEn,
    output logic [11:0] wrAddr,
    output logic [31:0] wrData,
    output logic wrPriv
);
    logic addrPhase;
    logic wrPend_q;
    logic [11:0] wrAddr_q;
    logic wrPriv_q;
    logic [31:0] hrdata_q;

    // Sub-word writes are dropped rather than merged
    assign addrPhase = hsel & htrans[1] & hready;
    assign rdAddr = haddr[11:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign wrEn = wrPend_q;
    assign wrAddr = wrAddr_q;
    assign wrData = hwdata;
    assign wrPriv = wrPriv_q;

    // Read data is sampled in the address phase, so it holds no same-edge write
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 12'h000;
            wrPriv_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            wrPend_q <= addrPhase & hwrite & (hsize == 3'b010);
            wrAddr_q <= addrPhase ? haddr[11:0] : wrAddr_q;
            wrPriv_q <= addrPhase ? hprot[1] : wrPriv_q;
            hrdata_q <= (addrPhase & ~hwrite) ? rdData : hrdata_q;
        end
    end
endmodule

/* rtl/access_checker.sv */
/*
 Permission check of one request against one page attribute entry.
 Assumes ID_WIDTH of at least 3; purely combinational.
*/
`timescale 1ns/1ps
module access_checker
    import mem_protect_pkg::*;
#(
    parameter int ID_WIDTH = 8
)
(
    // Request
    input wire logic [15:0] attr,
    input wire logic [ID_WIDTH-1:0] reqId,
    input wire logic reqLocal,
    input wire logic reqSuper,
    input wire logic [1:0] reqKind,
    input wire logic reqLineFill,
    input wire logic reqWriteback,
    // Verdict
    output logic permit,
    output logic [5:0] accessCode,
    output logic [6:0] statusId
);
    logic directId;
    logic idOk;
    logic [1:0] effKind;
    logic [2:0] needBit;
    logic [5:0] idField;

    assign idField = attr[PA_ID0_BIT +: NUM_DIRECT_IDS];
    assign directId = reqId < ID_WIDTH'(NUM_DIRECT_IDS);
    assign idOk = reqLocal ? attr[PA_LOCAL_BIT] : directId ? idField[reqId[2:0]] : attr[PA_ID_OTHER_BIT];
    // Line fills check as reads, victim writebacks as writes
    assign effKind = reqLineFill ? KIND_READ : reqWriteback ? KIND_WRITE : reqKind;
    assign needBit = 3'(reqSuper ? 5 - effKind : 2 - effKind);
    assign permit = idOk & attr[needBit];
    assign accessCode = reqLineFill ? ACC_LINE_FILL : reqWriteback ? ACC_WRITEBACK : 6'(6'h01 << needBit);

    generate
        if (ID_WIDTH >= FS_ID_W)
        begin : g_trunc
            assign statusId = reqLocal ? 7'h00 : reqId[6:0];
        end
        else
        begin : g_extend
            assign statusId = reqLocal ? 7'h00 : 7'(reqId);
        end
    endgenerate
endmodule

/* rtl/mem_protect_fault_capture.sv */
/*
 Memory protection block: page attribute registers, access checking
 and single-fault capture with one exception output.
 Assumes one requestor port from the memory controller, an AHB-Lite
 register bus and an exception controller that takes a one-cycle pulse.
*/
`timescale 1ns/1ps
module mem_protect_fault_capture
    import mem_protect_pkg::*;
#(
    parameter int NUM_PAGES = 16,
    parameter int PAGE_SHIFT = 10,
    parameter int ID_WIDTH = 8,
    parameter bit HAS_EXCEPTION = 1'b1,
    parameter logic [31:0] PAGE_RESET = 32'h0000_FF3F
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,

    // AHB-Lite register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [3:0] hprot,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,

    // Requestor access port
    input wire logic reqValid,
    input wire logic [31:0] reqAddr,
    input wire logic [ID_WIDTH-1:0] reqId,
    input wire logic reqLocal,
    input wire logic reqSuper,
    input wire logic [1:0] reqKind,
    input wire logic reqLineFill,
    input wire logic reqWriteback,
    output logic reqPermit,
    output logic memAccessEn,

    // Exception and status
    output logic protException,
    output logic protectionLock
);
    localparam int PAGE_IDX_W = (NUM_PAGES > 1) ? $clog2(NUM_PAGES) : 1;

    // Register bus side
    logic [11:0] rdAddr;
    logic [31:0] rdData;
    logic wrEn;
    logic [11:0] wrAddr;
    logic [31:0] wrData;
    logic wrPriv;

    // Page attribute storage
    logic [15:0] pageAttr_q [NUM_PAGES];
    logic [15:0] pageAttr_d [NUM_PAGES];
    logic [NUM_PAGES-1:0] pageWrSel;
    logic pageWrAllowed;

    // Lock
    logic lock_q;
    logic lock_d;
    logic lockWr;

    // Request check
    logic [PAGE_IDX_W-1:0] reqPage;
    logic reqPageHit;
    logic [15:0] reqAttr;
    logic checkPermit;
    logic [5:0] accessCode;
    logic [6:0] statusId;
    logic violation;

    // Fault capture view for the read mux
    logic [31:0] faultAddrView;
    logic [31:0] faultStatView;
    logic faultClrCmd;

    // Register decode
    logic rdIsPage;
    logic [PAGE_IDX_W-1:0] rdPageIdx;
    logic [31:0] rdPageWord;
    logic wrIsPage;
    logic [PAGE_IDX_W-1:0] wrPageIdx;

    function automatic logic isPageOfs(input logic [11:0] ofs);
        logic [11:0] rel;
        rel = ofs - PAGE_BASE_OFS;
        isPageOfs = (ofs >= PAGE_BASE_OFS) && (rel[1:0] == 2'b00) && (32'(rel[11:2]) < NUM_PAGES);
    endfunction

    function automatic logic [PAGE_IDX_W-1:0] pageIdxOf(input logic [11:0] ofs);
        logic [11:0] rel;
        rel = ofs - PAGE_BASE_OFS;
        pageIdxOf = PAGE_IDX_W'(rel[11:2]);
    endfunction

    ahb_reg_slave u_bus
    (
        .clock(clock),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hprot(hprot),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrPriv(wrPriv)
    );

    // Page attribute write path
    assign wrIsPage = isPageOfs(wrAddr);
    assign wrPageIdx = pageIdxOf(wrAddr);
    // Only supervisor writes reach the pages, and never while locked
    assign pageWrAllowed = wrEn & wrIsPage & wrPriv & ~lock_q;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PAGES; gp++)
        begin : g_page
            assign pageWrSel[gp] = pageWrAllowed & (wrPageIdx == PAGE_IDX_W'(gp));
            // Only the 14 meaningful bits are kept; bits 7:6 always store zero
            assign pageAttr_d[gp] = pageWrSel[gp] ? (wrData[15:0] & PA_USED_MASK[15:0]) : pageAttr_q[gp];

            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pageAttr_q[gp] <= PAGE_RESET[15:0] & PA_USED_MASK[15:0];
                end
                else
                begin
                    pageAttr_q[gp] <= pageAttr_d[gp];
                end
            end
        end
    endgenerate

    // Protection lock: engage and release bits, supervisor only
    assign lockWr = wrEn & wrPriv & (wrAddr == LOCK_CTL_OFS);
    assign lock_d = (lockWr & wrData[LOCK_ENGAGE_BIT]) ? 1'b1 :
                    (lockWr & wrData[LOCK_RELEASE_BIT]) ? 1'b0 : lock_q;
    assign protectionLock = lock_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_q <= 1'b0;
        end
        else
        begin
            lock_q <= lock_d;
        end
    end

    // Request check against the addressed page
    assign reqPage = reqAddr[PAGE_SHIFT +: PAGE_IDX_W];
    assign reqPageHit = 32'(reqPage) < NUM_PAGES;
    assign reqAttr = reqPageHit ? pageAttr_q[reqPage] : 16'h0000;

    access_checker #(
        .ID_WIDTH(ID_WIDTH)
    ) u_check
    (
        .attr(reqAttr),
        .reqId(reqId),
        .reqLocal(reqLocal),
        .reqSuper(reqSuper),
        .reqKind(reqKind),
        .reqLineFill(reqLineFill),
        .reqWriteback(reqWriteback),
        .permit(checkPermit),
        .accessCode(accessCode),
        .statusId(statusId)
    );

    // Pages beyond the implemented range deny everything
    assign reqPermit = checkPermit & reqPageHit;
    // The memory only sees an enable for permitted accesses
    assign memAccessEn = reqValid & reqPermit;
    assign violation = reqValid & ~reqPermit;

    // Clear command: only a one in bit 0 acts, from any privilege
    assign faultClrCmd = wrEn & (wrAddr == FAULT_CLR_OFS) & wrData[FAULT_CLR_BIT];

    generate
        if (HAS_EXCEPTION)
        begin : g_fault
            fault_state_e state_q;
            fault_state_e state_d;
            logic [31:0] faultAddr_q;
            logic [31:0] faultAddr_d;
            logic [31:0] faultStat_q;
            logic [31:0] faultStat_d;
            logic exc_q;
            logic capture;
            logic [31:0] newStatus;

            // Status word mirrors the attribute layout
            assign newStatus = {16'h0000, statusId, reqLocal, 2'b00, accessCode};

            // Capture when empty, or when a clear and a violation meet;
            // the new fault wins over the clear so it is never lost
            always_comb
            begin
                capture = 1'b0;
                state_d = state_q;
                unique case (state_q)
                    FAULT_EMPTY:
                    begin
                        capture = violation;
                    end
                    FAULT_HELD:
                    begin
                        capture = violation & faultClrCmd;
                        if (faultClrCmd & ~violation)
                        begin
                            state_d = FAULT_EMPTY;
                        end
                    end
                endcase
                if (capture)
                begin
                    state_d = FAULT_HELD;
                end
            end

            // Software writes to the address register have no path here
            assign faultAddr_d = capture ? reqAddr :
                                 (faultClrCmd ? FAULT_ADDR_RESET : faultAddr_q);
            assign faultStat_d = capture ? newStatus :
                                 (faultClrCmd ? FAULT_STAT_RESET : faultStat_q);

            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    state_q <= FAULT_EMPTY;
                    faultAddr_q <= FAULT_ADDR_RESET;
                    faultStat_q <= FAULT_STAT_RESET;
                    exc_q <= 1'b0;
                end
                else
                begin
                    state_q <= state_d;
                    faultAddr_q <= faultAddr_d;
                    faultStat_q <= faultStat_d;
                    exc_q <= capture;
                end
            end

            // Local to this block; other blocks see the same access on their own
            assign protException = exc_q;
            assign faultAddrView = faultAddr_q;
            assign faultStatView = faultStat_q;
        end
        else
        begin : g_no_fault
            // No exception path: the fault registers read as unmapped
            assign protException = 1'b0;
            assign faultAddrView = 32'h0000_0000;
            assign faultStatView = 32'h0000_0000;
        end
    endgenerate

    // Read mux
    assign rdIsPage = isPageOfs(rdAddr);
    assign rdPageIdx = pageIdxOf(rdAddr);
    assign rdPageWord = {16'h0000, pageAttr_q[rdPageIdx]};

    // Command register is write only and reads zero, as does any gap
    always_comb
    begin
        rdData = 32'h0000_0000;
        if (rdIsPage)
        begin
            rdData = rdPageWord;
        end
        else if (rdAddr == FAULT_ADDR_OFS)
        begin
            rdData = faultAddrView;
        end
        else if (rdAddr == FAULT_STAT_OFS)
        begin
            rdData = faultStatView;
        end
        else if (rdAddr == LOCK_CTL_OFS)
        begin
            rdData = {31'h0000_0000, lock_q};
        end
    end

endmodule

/* bench/mem_protect_asserts.sv */
/*
 Checker for the protection block: exception pulse, fault capture and clear.
 Assumes word transfers only and hready tied to hreadyout.
*/
`timescale 1ns/1ps
module mem_protect_asserts
    import mem_protect_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // Requestor and exception
    input wire logic reqValid,
    input wire logic [31:0] reqAddr,
    input wire logic reqPermit,
    input wire logic memAccessEn,
    input wire logic protException
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic clrPend_q, held_q;
    logic [31:0] lastAddr_q, expAddr_q;
    wire taken = hsel && htrans[1];
    wire rdFar = taken && !hwrite && haddr[11:0] == FAULT_ADDR_OFS;
    wire rdFault = rdFar || (taken && !hwrite && haddr[11:0] == FAULT_STAT_OFS);
    wire clrNow = clrPend_q && hwdata[FAULT_CLR_BIT];
    wire bad = reqValid && !reqPermit;
    // Held mirrors the block one cycle late, so the pulse cycle is excluded below
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clrPend_q <= 1'b0;
            held_q <= 1'b0;
            lastAddr_q <= 32'h0000_0000;
            expAddr_q <= 32'h0000_0000;
        end
        else
        begin
            clrPend_q <= taken && hwrite && haddr[11:0] == FAULT_CLR_OFS;
            held_q <= (protException || held_q) && !clrNow;
            lastAddr_q <= reqAddr;
            expAddr_q <= protException ? lastAddr_q : expAddr_q;
        end
    end
    a_access_gate: assert property (memAccessEn == (reqValid && reqPermit))
        else $error("memory enable differs from valid and permit");
    a_one_pulse: assert property (protException && !clrNow |=> !protException)
        else $error("exception pulse longer than one cycle");
    a_pulse_cause: assert property (protException |-> $past(bad))
        else $error("exception without a denied access");
    a_held_quiet: assert property (held_q && !clrNow && bad |=> !protException)
        else $error("exception raised while a fault is held");
    a_fresh_record: assert property (!held_q && !protException && bad |=> protException)
        else $error("violation with no fault held gave no exception");
    a_far_capture: assert property (rdFar && held_q |=> hrdata == expAddr_q)
        else $error("fault address differs from the faulting address");
    a_clear_zero: assert property ((clrNow && !bad) ##1 rdFault |=> hrdata == 32'h0000_0000)
        else $error("fault register not zero after clear");
    a_rdata_stands: assert property (!$stable(hrdata) |-> $past(taken && !hwrite))
        else $error("read data changed without a read");
    c_pulse: cover property (protException);
    c_clear: cover property (clrNow && held_q);
    c_far_read: cover property (rdFar && held_q);
endmodule

bind mem_protect_fault_capture mem_protect_asserts u_asserts (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hrdata(hrdata), .reqValid(reqValid), .reqAddr(reqAddr), .reqPermit(reqPermit),
    .memAccessEn(memAccessEn), .protException(protException)
);

/* bench/req_model.sv */
/*
 Requestor model: CPU, DMA or other master making one access at a time.
 Assumes access is called at a rising clock edge; returns at the next one.
*/
`timescale 1ns/1ps
module req_model
#(
    parameter int ID_WIDTH = 8
)
(
    // Clock
    input wire logic clock,
    // Requestor port
    output logic reqValid,
    output logic [31:0] reqAddr,
    output logic [ID_WIDTH-1:0] reqId,
    output logic reqLocal,
    output logic reqSuper,
    output logic [1:0] reqKind,
    output logic reqLineFill,
    output logic reqWriteback,
    input wire logic reqPermit
);
    initial
    begin
        reqValid = 1'b0;
        reqAddr = 32'h0000_0000;
        reqId = '0;
        {reqLocal, reqSuper, reqKind, reqLineFill, reqWriteback} = 6'h00;
    end
    // Mode is {local, supervisor, kind, line fill, writeback}
    task automatic access(input logic [31:0] addr, input logic [ID_WIDTH-1:0] id, input logic [5:0] mode,
        output logic permit);
        reqValid <= 1'b1;
        reqAddr <= addr;
        reqId <= id;
        {reqLocal, reqSuper, reqKind, reqLineFill, reqWriteback} <= mode;
        @(posedge clock);
        permit = reqPermit;
        reqValid <= 1'b0;
        // Idle lines carry no stale copy of the last access
        reqAddr <= ~addr;
        reqId <= ~id;
        {reqLocal, reqSuper, reqKind, reqLineFill, reqWriteback} <= ~mode;
    endtask
endmodule

/* bench/mem_protect_fault_capture_bench.sv */
/*
 Bench for the protection block: registers over AHB-Lite, fault capture, hold and clear.
 Assumes a zero-wait slave that alone serves the bus.
*/
`timescale 1ns/1ps
module mem_protect_fault_capture_bench;
    import mem_protect_pkg::*;
    localparam logic [31:0] RST_PAGE = 32'h0000_A5A5;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam logic [31:0] BAD = 32'hABCD_0400;
    localparam logic [5:0] MODES [9] = '{6'h10, 6'h14, 6'h18, 6'h00, 6'h04, 6'h08, 6'h02, 6'h01, 6'h30};
    localparam logic [5:0] CODES [9] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h3F, 6'h12, 6'h20};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [3:0] hprot = 4'b0011;
    logic [31:0] haddr = ZERO, hwdata = ZERO, hrdata;
    logic hreadyout, hresp, reqValid, reqLocal, reqSuper, reqLineFill, reqWriteback;
    logic reqPermit, memAccessEn, protException, protectionLock;
    logic [31:0] reqAddr;
    logic [7:0] reqId;
    logic [1:0] reqKind;
    int n_errors = 0, n_compared = 0, cycles = 0;
    always #4 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            conclude();
        end
    end
    mem_protect_fault_capture #(.PAGE_RESET(RST_PAGE)) u_dut (
        .clock(clock), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .reqValid(reqValid), .reqAddr(reqAddr), .reqId(reqId),
        .reqLocal(reqLocal), .reqSuper(reqSuper), .reqKind(reqKind), .reqLineFill(reqLineFill),
        .reqWriteback(reqWriteback), .reqPermit(reqPermit), .memAccessEn(memAccessEn),
        .protException(protException), .protectionLock(protectionLock));
    req_model u_req (
        .clock(clock), .reqValid(reqValid), .reqAddr(reqAddr), .reqId(reqId), .reqLocal(reqLocal),
        .reqSuper(reqSuper), .reqKind(reqKind), .reqLineFill(reqLineFill), .reqWriteback(reqWriteback),
        .reqPermit(reqPermit));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic flag(input logic got, input logic exp);
        check({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask
    // Called at a rising edge; returns at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [11:0] ofs, input logic [31:0] d, output logic [31:0] q);
        htrans <= 2'b10;
        haddr <= {20'h0_0000, ofs};
        hwrite <= wr;
        @(posedge clock);
        while (hreadyout !== 1'b1)
            @(posedge clock);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1)
            @(posedge clock);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        logic [31:0] junk;
        bus(1'b1, ofs, d, junk);
    endtask
    task automatic rdchk(input logic [11:0] ofs, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, ofs, ZERO, got);
        check(got, exp);
    endtask
    task automatic hit(input logic [31:0] addr, input logic [7:0] id, input logic [5:0] mode, input logic pulse);
        logic permit;
        u_req.access(addr, id, mode, permit);
        flag(permit, 1'b0);
        #1;
        flag(protException, pulse);
        @(posedge clock);
        #1;
        flag(protException, 1'b0);
        @(posedge clock);
    endtask
    task automatic t_reset();
        rdchk(PAGE_BASE_OFS, RST_PAGE & PA_USED_MASK);
        rdchk(PAGE_BASE_OFS + 12'h03C, RST_PAGE & PA_USED_MASK);
        rdchk(FAULT_ADDR_OFS, ZERO);
        rdchk(12'h200, ZERO);
    endtask
    task automatic t_codes();
        wr(PAGE_BASE_OFS + 12'h004, 32'hFFFF_FF00);
        rdchk(PAGE_BASE_OFS + 12'h004, 32'h0000_FF00);
        for (int i = 0; i < 9; i++)
        begin
            hit(BAD + 32'(i * 16), 8'hC0 | 8'(i), MODES[i], 1'b1);
            rdchk(FAULT_ADDR_OFS, BAD + 32'(i * 16));
            rdchk(FAULT_STAT_OFS, {16'h0000, MODES[i][5] ? 8'h01 : {7'h40 | 7'(i), 1'b0}, 2'b00, CODES[i]});
            wr(FAULT_CLR_OFS, 32'h0000_0001);
        end
    endtask
    task automatic t_hold();
        hit(BAD, 8'h07, 6'h14, 1'b1);
        hit(BAD + 32'h0000_0008, 8'h09, 6'h10, 1'b0);
        wr(FAULT_ADDR_OFS, 32'h1234_5678);
        wr(FAULT_CLR_OFS, ZERO);
        wr(FAULT_CLR_OFS, 32'hFFFF_FFFE);
        rdchk(FAULT_ADDR_OFS, BAD);
        rdchk(FAULT_STAT_OFS, 32'h0000_0E10);
        wr(FAULT_CLR_OFS, 32'h0000_0001);
        rdchk(FAULT_ADDR_OFS, ZERO);
        rdchk(FAULT_STAT_OFS, ZERO);
        hit(BAD + 32'h0000_0004, 8'h03, 6'h08, 1'b1);
        rdchk(FAULT_ADDR_OFS, BAD + 32'h0000_0004);
        wr(FAULT_CLR_OFS, 32'h0000_0001);
    endtask
    task automatic t_lock();
        logic permit;
        wr(PAGE_BASE_OFS + 12'h008, 32'h0000_0420);
        wr(LOCK_CTL_OFS, 32'h0000_0001);
        rdchk(LOCK_CTL_OFS, 32'h0000_0001);
        wr(PAGE_BASE_OFS + 12'h008, 32'hFFFF_FFFF);
        rdchk(PAGE_BASE_OFS + 12'h008, 32'h0000_0420);
        wr(LOCK_CTL_OFS, 32'h0000_0002);
        wr(PAGE_BASE_OFS + 12'h008, 32'h0000_0820);
        rdchk(PAGE_BASE_OFS + 12'h008, 32'h0000_0820);
        u_req.access(32'h0000_0800, 8'h01, 6'h10, permit);
        flag(permit, 1'b1);
        @(posedge clock);
        hit(32'h0000_0800, 8'h01, 6'h00, 1'b1);
        hit(32'h0000_0804, 8'h02, 6'h10, 1'b0);
        wr(FAULT_CLR_OFS, 32'h0000_0001);
    endtask
    task automatic conclude();
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_codes();
        t_hold();
        t_lock();
        conclude();
    end
endmodule
